// ---- src/atpf_pkg.sv ----
package atpf_pkg;

	// ==========================================================
	// Field positions inside the header quadlets
	// ==========================================================
	localparam int unsigned SPD_LSB = 16;
	localparam int unsigned TLABEL_LSB = 10;
	localparam int unsigned RETRY_LSB = 8;
	localparam int unsigned TCODE_LSB = 4;
	localparam int unsigned PRIO_LSB = 0;
	localparam int unsigned DESTID_LSB = 16;
	localparam int unsigned RCODE_LSB = 12;
	localparam int unsigned DLEN_LSB = 16;

	// ==========================================================
	// Speed, retry and response codes
	// ==========================================================
	localparam logic [1:0] SPD_100 = 2'h0;
	localparam logic [1:0] SPD_200 = 2'h1;
	localparam logic [1:0] SPD_400 = 2'h2;
	localparam logic [1:0] SPD_RSVD = 2'h3;
	localparam logic [1:0] RETRY_NEW = 2'h0;
	localparam logic [1:0] RETRY_X = 2'h1;
	localparam logic [1:0] RETRY_A = 2'h2;
	localparam logic [1:0] RETRY_B = 2'h3;
	localparam logic [3:0] RC_COMPLETE = 4'h0;
	localparam logic [3:0] RC_CONFLICT = 4'h4;
	localparam logic [3:0] RC_DATA_ERR = 4'h5;
	localparam logic [3:0] RC_TYPE_ERR = 4'h6;
	localparam logic [3:0] RC_ADDR_ERR = 4'h7;

	// ==========================================================
	// Transaction codes
	// ==========================================================
	localparam logic [3:0] TC_WR_QUAD = 4'h0;
	localparam logic [3:0] TC_WR_BLK = 4'h1;
	localparam logic [3:0] TC_WR_RESP = 4'h2;
	localparam logic [3:0] TC_RD_QUAD = 4'h4;
	localparam logic [3:0] TC_RD_BLK = 4'h5;
	localparam logic [3:0] TC_RD_QRESP = 4'h6;
	localparam logic [3:0] TC_RD_BRESP = 4'h7;
	localparam logic [3:0] TC_LOCK_REQ = 4'h9;
	localparam logic [3:0] TC_LOCK_RESP = 4'hB;

	// ==========================================================
	// Header sizes and write pacing
	// ==========================================================
	localparam logic [2:0] HDR_SHORT = 3'h3;
	localparam logic [2:0] HDR_FULL = 3'h4;
	localparam logic [2:0] AUTO_START_QUAD = 3'h3;
	localparam logic [2:0] AUTO_START_BLK = 3'h4;
	localparam logic [2:0] WR_SPACING = 3'h4;
	localparam logic [5:0] TLABEL_RESET = 6'h00;

	// ==========================================================
	// Carriers and state
	// ==========================================================
	typedef struct packed {
		logic [1:0] spd;
		logic [1:0] retry_code;
		logic [3:0] prio;
		logic [3:0] tcode;
		logic [5:0] tlabel;
		logic [9:0] bus;
		logic [5:0] node;
		logic [15:0] off_hi;
		logic [31:0] off_lo;
		logic [3:0] rcode;
		logic [15:0] data_length;
		logic [15:0] ext_tcode;
		logic [31:0] qdata;
		logic auto_hdr;
	} atpf_req_s;

	typedef struct packed {
		logic wr;
		logic sel_last;
		logic [31:0] wdata;
	} atpf_port_s;

	typedef enum logic [1:0] {
		ATPF_IDLE,
		ATPF_HDR,
		ATPF_FETCH,
		ATPF_PAYLOAD
	} atpf_state_e;

	typedef struct packed {
		atpf_state_e st;
		logic [3:0][31:0] hdr;
		logic [2:0] nhdr;
		logic [2:0] idx;
		logic [13:0] pl_left;
		logic [2:0] gap;
		logic [31:0] data;
		logic [5:0] tlabel_ctr;
		atpf_port_s port;
		logic req_ready;
		logic pl_ready;
		logic done;
		logic err;
	} atpf_host_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} atpf_sync_s;

endpackage : atpf_pkg

// ---- src/atpf_sync.sv ----
`timescale 1ns/1ns
module atpf_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);

	atpf_pkg::atpf_sync_s r;
	atpf_pkg::atpf_sync_s next_r;

	// ==========================================================
	// Three stages; the output moves only once stages two and three agree
	// ==========================================================
	always_comb
	begin
		next_r = r;
		next_r.s1 = d;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		if (r.s2 == r.s3)
		begin
			next_r.q = r.s3;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign q = r.q;

endmodule : atpf_sync

// ---- src/atpf_host.sv ----
`timescale 1ns/1ns
module atpf_host #(
	parameter bit CABLE = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire atpf_pkg::atpf_req_s req,
	input wire logic pl_valid,
	output logic pl_ready,
	input wire logic [31:0] pl_data,
	output logic done,
	output logic err,
	output atpf_pkg::atpf_port_s port,
	input wire logic port_busy
);

	atpf_pkg::atpf_host_s r;
	atpf_pkg::atpf_host_s next_r;
	logic busy_s;

	// ==========================================================
	// Code classification
	// ==========================================================
	function automatic logic tc_is_request(input logic [3:0] tc);
		tc_is_request = (tc == atpf_pkg::TC_WR_QUAD) || (tc == atpf_pkg::TC_WR_BLK) ||
			(tc == atpf_pkg::TC_RD_QUAD) || (tc == atpf_pkg::TC_RD_BLK) || (tc == atpf_pkg::TC_LOCK_REQ);
	endfunction : tc_is_request

	function automatic logic tc_has_payload(input logic [3:0] tc);
		tc_has_payload = (tc == atpf_pkg::TC_WR_BLK) || (tc == atpf_pkg::TC_RD_BRESP) ||
			(tc == atpf_pkg::TC_LOCK_REQ) || (tc == atpf_pkg::TC_LOCK_RESP);
	endfunction : tc_has_payload

	function automatic logic tc_auto_ok(input logic [3:0] tc);
		tc_auto_ok = (tc == atpf_pkg::TC_WR_QUAD) || (tc == atpf_pkg::TC_WR_BLK) ||
			(tc == atpf_pkg::TC_RD_QRESP) || (tc == atpf_pkg::TC_RD_BRESP) || (tc == atpf_pkg::TC_LOCK_REQ);
	endfunction : tc_auto_ok

	function automatic logic rcode_bad(input logic [3:0] rc);
		rcode_bad = (rc != atpf_pkg::RC_COMPLETE) && ((rc < atpf_pkg::RC_CONFLICT) || (rc > atpf_pkg::RC_ADDR_ERR));
	endfunction : rcode_bad

	function automatic logic req_bad(input atpf_pkg::atpf_req_s q);
		req_bad = (q.spd == atpf_pkg::SPD_RSVD) ||
			(tc_is_request(q.tcode) && (q.off_lo[1:0] != 2'h0)) ||
			(!tc_is_request(q.tcode) && rcode_bad(q.rcode));
	endfunction : req_bad

	atpf_sync u_busy (
		.clk(clk),
		.rst_n(rst_n),
		.d(port_busy),
		.q(busy_s)
	);

	// ==========================================================
	// Packet sequencer
	// ==========================================================
	always_comb
	begin
		logic [5:0] lbl;
		logic [15:0] pl_words;
		logic last;
		lbl = '0;
		pl_words = '0;
		last = 1'b0;
		next_r = r;
		next_r.port.wr = 1'b0;
		next_r.port.sel_last = 1'b0;
		next_r.done = 1'b0;
		next_r.err = 1'b0;
		if (r.gap != 3'h0)
		begin
			next_r.gap = r.gap - 3'h1;
		end
		case (r.st)
			atpf_pkg::ATPF_IDLE:
			begin
				if (req_valid && r.req_ready)
				begin
					if (req_bad(req))
					begin
						next_r.err = 1'b1;
					end
					else
					begin
						lbl = tc_is_request(req.tcode) ? r.tlabel_ctr : req.tlabel;
						if (tc_is_request(req.tcode))
						begin
							next_r.tlabel_ctr = r.tlabel_ctr + 6'h01;
						end
						next_r.hdr[0] = '0;
						next_r.hdr[0][atpf_pkg::SPD_LSB +: 2] = req.spd;
						next_r.hdr[0][atpf_pkg::TLABEL_LSB +: 6] = lbl;
						next_r.hdr[0][atpf_pkg::RETRY_LSB +: 2] = req.retry_code;
						next_r.hdr[0][atpf_pkg::TCODE_LSB +: 4] = req.tcode;
						next_r.hdr[0][atpf_pkg::PRIO_LSB +: 4] = CABLE ? 4'h0 : req.prio;
						next_r.hdr[1] = '0;
						next_r.hdr[1][atpf_pkg::DESTID_LSB +: 16] = {req.bus, req.node};
						if (tc_is_request(req.tcode))
						begin
							next_r.hdr[1][15:0] = req.off_hi;
							next_r.hdr[2] = req.off_lo;
						end
						else
						begin
							next_r.hdr[1][atpf_pkg::RCODE_LSB +: 4] = req.rcode;
							next_r.hdr[2] = '0;
						end
						if ((req.tcode == atpf_pkg::TC_WR_QUAD) || (req.tcode == atpf_pkg::TC_RD_QRESP))
						begin
							next_r.hdr[3] = req.qdata;
						end
						else
						begin
							next_r.hdr[3] = {req.data_length, req.ext_tcode};
						end
						// Quadlet read requests and write responses stop after three quadlets.
						next_r.nhdr = ((req.tcode == atpf_pkg::TC_WR_RESP) || (req.tcode == atpf_pkg::TC_RD_QUAD)) ?
							atpf_pkg::HDR_SHORT : atpf_pkg::HDR_FULL;
						if (req.auto_hdr && tc_auto_ok(req.tcode))
						begin
							next_r.idx = ((req.tcode == atpf_pkg::TC_WR_QUAD) || (req.tcode == atpf_pkg::TC_RD_QRESP)) ?
								atpf_pkg::AUTO_START_QUAD : atpf_pkg::AUTO_START_BLK;
						end
						else
						begin
							next_r.idx = 3'h0;
						end
						pl_words = req.data_length + 16'h0003;
						next_r.pl_left = tc_has_payload(req.tcode) ? pl_words[15:2] : 14'h0000;
						next_r.req_ready = 1'b0;
						if (next_r.idx < next_r.nhdr)
						begin
							next_r.st = atpf_pkg::ATPF_HDR;
						end
						else if (next_r.pl_left != 14'h0000)
						begin
							next_r.st = atpf_pkg::ATPF_FETCH;
							next_r.pl_ready = 1'b1;
						end
						else
						begin
							next_r.done = 1'b1;
							next_r.req_ready = 1'b1;
						end
					end
				end
			end
			atpf_pkg::ATPF_HDR:
			begin
				if (!busy_s && (r.gap == 3'h0))
				begin
					last = (r.idx == r.nhdr - 3'h1) && (r.pl_left == 14'h0000);
					next_r.port.wr = 1'b1;
					next_r.port.wdata = r.hdr[r.idx];
					next_r.port.sel_last = last;
					next_r.gap = atpf_pkg::WR_SPACING - 3'h1;
					next_r.idx = r.idx + 3'h1;
					if (last)
					begin
						next_r.st = atpf_pkg::ATPF_IDLE;
						next_r.done = 1'b1;
						next_r.req_ready = 1'b1;
					end
					else if (r.idx == r.nhdr - 3'h1)
					begin
						next_r.st = atpf_pkg::ATPF_FETCH;
						next_r.pl_ready = 1'b1;
					end
				end
			end
			atpf_pkg::ATPF_FETCH:
			begin
				if (pl_valid && r.pl_ready)
				begin
					next_r.data = pl_data;
					next_r.pl_ready = 1'b0;
					next_r.st = atpf_pkg::ATPF_PAYLOAD;
				end
			end
			atpf_pkg::ATPF_PAYLOAD:
			begin
				if (!busy_s && (r.gap == 3'h0))
				begin
					last = (r.pl_left == 14'h0001);
					next_r.port.wr = 1'b1;
					next_r.port.wdata = r.data;
					next_r.port.sel_last = last;
					next_r.gap = atpf_pkg::WR_SPACING - 3'h1;
					next_r.pl_left = r.pl_left - 14'h0001;
					if (last)
					begin
						next_r.st = atpf_pkg::ATPF_IDLE;
						next_r.done = 1'b1;
						next_r.req_ready = 1'b1;
					end
					else
					begin
						next_r.st = atpf_pkg::ATPF_FETCH;
						next_r.pl_ready = 1'b1;
					end
				end
			end
			default:
			begin
				next_r.st = atpf_pkg::ATPF_IDLE;
				next_r.req_ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			r <= '0;
			r.st <= atpf_pkg::ATPF_IDLE;
			r.tlabel_ctr <= atpf_pkg::TLABEL_RESET;
			r.req_ready <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign req_ready = r.req_ready;
	assign pl_ready = r.pl_ready;
	assign done = r.done;
	assign err = r.err;
	assign port = r.port;

	// ==========================================================
	// Checks
	// ==========================================================
	property p_spd_refused;
		@(posedge clk) disable iff (!rst_n)
		(req_valid && req_ready && (req.spd == atpf_pkg::SPD_RSVD)) |=> (err && !port.wr);
	endproperty
	a_spd_refused: assert property (p_spd_refused) else $error("reserved speed not refused");

	property p_align_refused;
		@(posedge clk) disable iff (!rst_n)
		(req_valid && req_ready && tc_is_request(req.tcode) && (req.off_lo[1:0] != 2'h0)) |=> err ##1 req_ready;
	endproperty
	a_align_refused: assert property (p_align_refused) else $error("misaligned offset not refused");

	property p_rcode_refused;
		@(posedge clk) disable iff (!rst_n)
		(req_valid && req_ready && !tc_is_request(req.tcode) && rcode_bad(req.rcode)) |=> err;
	endproperty
	a_rcode_refused: assert property (p_rcode_refused) else $error("reserved response code not refused");

	property p_prio_zero;
		@(posedge clk) disable iff (!rst_n)
		(CABLE && req_valid && req_ready && !req_bad(req)) |=> (r.hdr[0][3:0] == 4'h0);
	endproperty
	a_prio_zero: assert property (p_prio_zero) else $error("priority not zero");

	property p_short_header;
		@(posedge clk) disable iff (!rst_n)
		(req_valid && req_ready && !req_bad(req) && (req.tcode == atpf_pkg::TC_RD_QUAD)) |=>
			(r.nhdr == atpf_pkg::HDR_SHORT) && (r.pl_left == 14'h0000);
	endproperty
	a_short_header: assert property (p_short_header) else $error("read request carries a data quadlet");

	property p_zero_length;
		@(posedge clk) disable iff (!rst_n)
		(req_valid && req_ready && !req_bad(req) && tc_has_payload(req.tcode) && (req.data_length == 16'h0000))
			|=> (r.pl_left == 14'h0000);
	endproperty
	a_zero_length: assert property (p_zero_length) else $error("zero length block expects payload");

	property p_last_closes;
		@(posedge clk) disable iff (!rst_n)
		(port.wr && port.sel_last) |-> (done && req_ready && !pl_ready);
	endproperty
	a_last_closes: assert property (p_last_closes) else $error("last register write does not end packet");

	property p_busy_respected;
		@(posedge clk) disable iff (!rst_n)
		port.wr |-> ($past(busy_s) == 1'b0) && !$past(port.wr);
	endproperty
	a_busy_respected: assert property (p_busy_respected) else $error("write issued while device busy");

	property p_lane_zero;
		@(posedge clk) disable iff (!rst_n)
		(pl_valid && pl_ready) |=> (r.data == $past(pl_data)) ##[1:300] (port.wr && (port.wdata == $past(r.data)));
	endproperty
	a_lane_zero: assert property (p_lane_zero) else $error("payload quadlet altered");

endmodule : atpf_host

// ---- tb/atpf_dev.sv ----
`timescale 1ns/1ns
// ==========================================================
// Device buffer model
// ==========================================================
module atpf_dev (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire atpf_pkg::atpf_port_s port,
	output logic port_busy
);
	int hold;
	int overrun;
	int packets;
	// Busy rises with the write itself, because the host sees it four cycles late.
	// A slow buffer needs four cycles per write, which the host's write spacing always leaves it.
	assign port_busy = slow && (port.wr || hold > 0);
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			hold <= 0;
			overrun <= 0;
			packets <= 0;
		end
		else if (port.wr)
		begin
			if (hold > 0)
				overrun <= overrun + 1;
			hold <= slow ? 3 : 0;
			if (port.sel_last)
				packets <= packets + 1;
		end
		else if (hold > 0)
			hold <= hold - 1;
	end
endmodule : atpf_dev

// ---- tb/async_transmit_packet_format_bench.sv ----
`timescale 1ns/1ns
module async_transmit_packet_format_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic pl_valid = 1'b0;
	logic [31:0] pl_data = 32'h0;
	logic slow = 1'b0;
	atpf_pkg::atpf_req_s req = '0;
	logic req_ready;
	logic pl_ready;
	logic done;
	logic err;
	logic port_busy;
	atpf_pkg::atpf_port_s port;
	int error_cnt = 0;
	int total_checks = 0;
	int cycles = 0;
	int sent_pkts = 0;
	logic pl_taken = 1'b0;
	logic [31:0] seed = 32'hCE55;
	logic [32:0] exp_q[$];
	logic [31:0] pl_q[$];
	logic [32:0] mon_x;
	logic [5:0] tag = 6'h00;
	logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hB};
	logic [15:0] lens [5] = '{16'h0, 16'h1, 16'h4, 16'h5, 16'hD};
	logic [3:0] rcodes [5] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7};

	always #5 clk = ~clk;

	atpf_host u_atpf_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req(req),
		.pl_valid(pl_valid), .pl_ready(pl_ready), .pl_data(pl_data), .done(done), .err(err), .port(port),
		.port_busy(port_busy));
	atpf_dev u_atpf_dev (.clk(clk), .rst_n(rst_n), .slow(slow), .port(port), .port_busy(port_busy));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Write monitor against the expected quadlet stream
	// ==========================================================
	always @(posedge clk)
	begin
		cycles++;
		if (cycles > 40000)
		begin
			error_cnt++;
			tally_and_finish();
		end
		else if (rst_n && port.wr === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk("stray_write", 32'h1, 32'h0);
			else
			begin
				mon_x = exp_q.pop_front();
				chk("wdata", port.wdata, mon_x[31:0]);
				chk("sel_last", 32'(port.sel_last), 32'(mon_x[32]));
				chk("done_at_last", 32'(done), 32'(mon_x[32]));
			end
		end
	end

	// ==========================================================
	// Payload source, stalling at random
	// ==========================================================
	always
	begin
		@(posedge clk);
		pl_taken = pl_valid && pl_ready === 1'b1;
		if (pl_taken)
			void'(pl_q.pop_front());
		#1;
		// A taken quadlet is replaced in one step, so valid never drops and rises in the same step.
		if (pl_taken || !pl_valid)
			pl_valid = pl_q.size() > 0 && (rnd() & 32'h1) != 0;
		pl_data = pl_valid ? pl_q[0] : ~pl_data;
	end

	function automatic atpf_pkg::atpf_req_s rand_req(input int k, input int p);
		atpf_pkg::atpf_req_s r;
		logic [159:0] raw;
		raw = {rnd(), rnd(), rnd(), rnd(), rnd()};
		r = raw[$bits(atpf_pkg::atpf_req_s) - 1:0];
		r.spd = 2'(rnd() % 3);
		r.retry_code = 2'(k + p);
		r.tcode = codes[k];
		r.off_lo[1:0] = 2'h0;
		r.rcode = rcodes[(k + p) % 5];
		r.data_length = lens[(k + p) % 5];
		r.auto_hdr = p > 0;
		return r;
	endfunction : rand_req

	task automatic send(input atpf_pkg::atpf_req_s r, input bit bad);
		int t;
		logic [31:0] w;
		logic [31:0] q[$];
		bit rq;
		rq = r.tcode inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h9};
		if (!bad)
		begin
			w = {14'h0, r.spd, rq ? tag : r.tlabel, r.retry_code, r.tcode, 4'h0};
			if (!(r.auto_hdr && r.tcode inside {4'h0, 4'h1, 4'h6, 4'h7, 4'h9}))
			begin
				q.push_back(w);
				q.push_back(rq ? {r.bus, r.node, r.off_hi} : {r.bus, r.node, r.rcode, 12'h0});
				q.push_back(rq ? r.off_lo : 32'h0);
			end
			if (!(r.tcode inside {4'h2, 4'h4}) && !(r.auto_hdr && r.tcode inside {4'h1, 4'h7, 4'h9}))
				q.push_back(r.tcode inside {4'h0, 4'h6} ? r.qdata : {r.data_length, r.ext_tcode});
			if (r.tcode inside {4'h1, 4'h7, 4'h9, 4'hB})
				for (t = 0; t < (r.data_length + 3) / 4; t++)
				begin
					w = rnd();
					pl_q.push_back(w);
					q.push_back(w);
				end
			if (rq)
				tag++;
			foreach (q[i])
				exp_q.push_back({i == q.size() - 1, q[i]});
			if (q.size() > 0)
				sent_pkts++;
		end
		req = r;
		req_valid = 1'b1;
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (req_ready !== 1'b1 && t < 100);
		#1;
		req_valid = 1'b0;
		req = ~r;
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (err !== 1'b1 && done !== 1'b1 && t < 2000);
		chk("refused", 32'(err), 32'(bad));
		chk("ready_after", 32'(req_ready), 32'h1);
		// The monitor pops the last quadlet at this same edge, so look only once it has run.
		#1;
		chk("left_over", 32'(exp_q.size()), 32'h0);
	endtask : send

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		atpf_pkg::atpf_req_s r;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		// Every code at each pass; pass 1 adds device stalls, and passes 1 and 2 add header insertion.
		for (int p = 0; p < 3; p++)
		begin
			slow = p == 1;
			for (int k = 0; k < 9; k++)
				send(rand_req(k, p), 1'b0);
		end
		slow = 1'b0;
		r = rand_req(3, 0);
		r.spd = atpf_pkg::SPD_RSVD;
		send(r, 1'b1);
		r = rand_req(0, 0);
		r.off_lo[1:0] = 2'h2;
		send(r, 1'b1);
		r = rand_req(5, 0);
		r.rcode = 4'h1;
		send(r, 1'b1);
		r.rcode = 4'h8;
		send(r, 1'b1);
		send(rand_req(4, 0), 1'b0);
		r = rand_req(1, 1);
		r.data_length = 16'h0000;
		send(r, 1'b0);
		chk("overrun", 32'(u_atpf_dev.overrun), 32'h0);
		chk("packets", 32'(u_atpf_dev.packets), 32'(sent_pkts));
		tally_and_finish();
	end
endmodule : async_transmit_packet_format_bench
